// ===== hdl/mio_defs.svh
// Functional notes
// - Up to 24 subchannels on A, 8 on B.
// - Per-device control held in private memory only.
// - Chaining fetches two command words into slot.
// - Identification addresses the slot's command record.
// - Transfers start only on controller requests.
// - Each channel keeps count, address, sequencing state.
// - One logical channel per device controller.
// - 470,000 B/s byte-wide, 940,000 B/s word-wide.
// - Channel A scales 8 to 24 via memory depth.
// - Memory move copies count words without CPU.
// - Move completion interrupts only when requested.
// - CPU starts only; events reported by interrupt.
// - Data chaining continues record; command chaining new record.
//
// Shared constants of the multiplexing I/O processor: command word fields,
// word steps, subchannel limits and rate figures. Included by the package; the core uses its macros.
`ifndef MIO_DEFS_SVH
`define MIO_DEFS_SVH

// Command word 0: order in [31:24], data address in [23:0].
`define MIO_W0_ORDER_HI 31
`define MIO_W0_ORDER_LO 24
`define MIO_W0_ADDR_HI 23
`define MIO_W0_ADDR_LO 0
// Command word 1: flags in [31:29], byte count in [15:0].
`define MIO_W1_DCHAIN 31
`define MIO_W1_CCHAIN 30
`define MIO_W1_IRQ 29
`define MIO_W1_CNT_HI 15
`define MIO_W1_CNT_LO 0

// Byte distance between consecutive command words and command pairs.
`define MIO_WORD_STEP 32'h0000_0004
`define MIO_PAIR_STEP 32'h0000_0008

// Documented subchannel limits.
`define MIO_NUM_A 24
`define MIO_NUM_B 8
`define MIO_MIN_A 8

// Rates and the clock they are measured against.
`define MIO_CLK_HZ 200000000
`define MIO_BYTE_RATE 470000
`define MIO_WIDE_RATE 940000
// Worst-case cycles the core spends on one service, memory wait excluded.
`define MIO_SERVICE_CYCLES 6

`endif

// ===== hdl/mio_pkg.sv
// Types shared by the multiplexing I/O processor core, its checker and its bench.
// Assumes mio_defs.svh is on the include path.
`include "mio_defs.svh"

package mio_pkg;

    // Controller service request, held stable while its request line is high.
    typedef struct packed {
        logic [4:0] id;
        logic dir_in;
        logic wide;
        logic [31:0] data;
    } mio_dev_s;

    // CPU start of a channel program.
    typedef struct packed {
        logic chan_b;
        logic [4:0] id;
        logic [31:0] cmd_addr;
    } mio_start_s;

    // CPU start of a memory-to-memory move; count is in words.
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] count;
        logic irq_en;
    } mio_move_s;

    // Source of an interrupt.
    typedef struct packed {
        logic is_move;
        logic chan_b;
        logic [4:0] id;
    } mio_irq_s;

    // One private memory slot.
    typedef struct packed {
        logic active;
        logic dchain;
        logic cchain;
        logic irq_en;
        logic [7:0] order;
        logic [31:0] addr;
        logic [15:0] cnt;
        logic [31:0] ptr;
    } mio_rec_s;

    typedef enum logic [2:0] {
        MIO_IDLE,
        MIO_FETCH0,
        MIO_FETCH1,
        MIO_XFER,
        MIO_MV_RD,
        MIO_MV_WR
    } mio_state_e;

endpackage : mio_pkg

// ===== hdl/mio_arb.sv
// Fixed-priority grant: the lowest-numbered request wins.
// Assumes requests from logic on the same clock.
`timescale 1ns/1ps

module mio_arb #(
    parameter int N = 4
) (
    // Requests and one-hot grant.
    input wire logic [N-1:0] req,
    output logic [N-1:0] gnt
);
    initial begin
        if (N < 1) begin
            $error("mio_arb needs at least one requester");
        end
    end

    // Isolate the lowest set bit; priority never rotates, so service order is
    // fully predictable at the cost of possible starvation of high indices.
    assign gnt = req & (~req + N'(1));

endmodule : mio_arb

// ===== hdl/mio_core.sv
// Multiplexing I/O processor core: private slot memory, command chaining,
// controller service on channels A and B, memory-to-memory move.
// Assumes controllers, CPU and memory are logic on the same clock; memory
// answers a held request with a one-cycle ack.
`timescale 1ns/1ps

module mio_core
    import mio_pkg::*;
#(
    parameter int NUM_A = `MIO_NUM_A,
    parameter int NUM_B = `MIO_NUM_B
) (
    // Clock and synchronous active-low reset.
    input wire logic clk,
    input wire logic rst_n,
    // CPU start of a channel program.
    input wire logic start_valid,
    input wire mio_pkg::mio_start_s start,
    output logic start_ready,
    // CPU start of a memory move.
    input wire logic move_valid,
    input wire mio_pkg::mio_move_s move,
    output logic move_ready,
    // Interrupt to the CPU.
    output logic irq,
    output mio_pkg::mio_irq_s irq_src,
    // Channel A controllers.
    input wire logic dev_a_req,
    input wire mio_pkg::mio_dev_s dev_a,
    output logic dev_a_ack,
    // Channel B controllers.
    input wire logic dev_b_req,
    input wire mio_pkg::mio_dev_s dev_b,
    output logic dev_b_ack,
    // Answer shared by both channels.
    output logic [31:0] dev_rdata,
    output logic dev_end,
    output logic dev_err,
    // Core memory.
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [3:0] mem_be,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    import mio_pkg::*;

    localparam int NUM_SUB = NUM_A + NUM_B;
    localparam int SW = $clog2(NUM_SUB);
    // Longest allowed service time per byte and per word, rounded down.
    localparam int BYTE_CYC = `MIO_CLK_HZ / `MIO_BYTE_RATE;
    localparam int WIDE_CYC = (4 * `MIO_CLK_HZ) / `MIO_WIDE_RATE;

    // Channel A grows with slot memory only, never with extra registers.
    initial begin
        if (NUM_A < `MIO_MIN_A || NUM_A > `MIO_NUM_A) begin
            $error("NUM_A out of range");
        end
        if (NUM_B < 1 || NUM_B > `MIO_NUM_B) begin
            $error("NUM_B out of range");
        end
        if (`MIO_SERVICE_CYCLES > BYTE_CYC || `MIO_SERVICE_CYCLES > WIDE_CYC) begin
            $error("Clock too slow for documented channel rate");
        end
    end

    // Private slot memory; no port reads or writes it directly.
    mio_rec_s priv_mem [NUM_SUB];

    mio_state_e state;
    logic [SW-1:0] slot;
    logic cur_b;
    logic cur_start;
    mio_dev_s cur;
    logic [31:0] w0;
    logic [31:0] mv_src;
    logic [31:0] mv_dst;
    logic [15:0] mv_cnt;
    logic mv_irq;
    logic mv_busy;

    // Requests: 0 CPU start, 1 channel A, 2 channel B, 3 move step.
    wire [3:0] arb_req = {mv_busy, dev_b_req, dev_a_req, start_valid & ~mv_busy};
    wire [3:0] gnt;
    wire idle = (state == MIO_IDLE);

    mio_arb #(
        .N(4)
    ) u_arb (
        .req(arb_req),
        .gnt(gnt)
    );

    // Slot index from identification; B slots follow the A slots.
    function automatic logic [SW-1:0] slot_of(input logic b, input logic [4:0] id);
        slot_of = b ? SW'(NUM_A + int'(id)) : SW'(id);
    endfunction : slot_of

    wire mio_dev_s pick = gnt[2] ? dev_b : dev_a;
    wire pick_b = gnt[2];
    wire id_ok = pick_b ? (int'(pick.id) < NUM_B) : (int'(pick.id) < NUM_A);
    wire [SW-1:0] pick_slot = slot_of(pick_b, pick.id);
    wire mio_rec_s pick_rec = priv_mem[pick_slot];
    wire mio_rec_s rec = priv_mem[slot];
    wire [SW-1:0] start_slot = slot_of(start.chan_b, start.id);
    wire start_ok = start.chan_b ? (int'(start.id) < NUM_B) : (int'(start.id) < NUM_A);

    // Transfer step, byte lane and remaining-count test for the current slot.
    wire [15:0] step = cur.wide ? 16'h0004 : 16'h0001;
    wire [1:0] lane = rec.addr[1:0];
    wire [3:0] byte_be = 4'h1 << pick_rec.addr[1:0];
    wire last = (rec.cnt <= step);
    wire chain = rec.dchain | rec.cchain;
    wire [31:0] rd_byte = {24'h00_0000, mem_rdata[8*lane +: 8]};

    // Handshake outputs; program starts are only taken when the arbiter grants them, move starts whenever idle with no move busy.
    assign start_ready = idle & gnt[0];
    assign move_ready = idle & ~mv_busy;
    assign mem_req = (state != MIO_IDLE);

    // Memory move parameters are latched on the start and consumed by steps.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mv_busy <= 1'b0;
            mv_src <= 32'h0000_0000;
            mv_dst <= 32'h0000_0000;
            mv_cnt <= 16'h0000;
            mv_irq <= 1'b0;
        end else if (move_valid && move_ready && move.count != 16'h0000) begin
            mv_busy <= 1'b1;
            mv_src <= move.src;
            mv_dst <= move.dst;
            mv_cnt <= move.count;
            mv_irq <= move.irq_en;
        end else if (state == MIO_MV_WR && mem_ack) begin
            mv_src <= mv_src + `MIO_WORD_STEP;
            mv_dst <= mv_dst + `MIO_WORD_STEP;
            mv_cnt <= mv_cnt - 16'h0001;
            if (mv_cnt == 16'h0001) begin
                mv_busy <= 1'b0;
            end
        end
    end

    // Main sequencer: one granted access runs to completion before the next.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= MIO_IDLE;
            slot <= '0;
            cur_b <= 1'b0;
            cur_start <= 1'b0;
            cur <= '0;
            w0 <= 32'h0000_0000;
            dev_a_ack <= 1'b0;
            dev_b_ack <= 1'b0;
            dev_rdata <= 32'h0000_0000;
            dev_end <= 1'b0;
            dev_err <= 1'b0;
            irq <= 1'b0;
            irq_src <= '0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_be <= 4'h0;
            mem_wdata <= 32'h0000_0000;
            for (int i = 0; i < NUM_SUB; i++) begin
                priv_mem[i] <= '0;
            end
        end else begin
            dev_a_ack <= 1'b0;
            dev_b_ack <= 1'b0;
            irq <= 1'b0;
            case (state)
                MIO_IDLE: begin
                    if (gnt[0]) begin
                        // CPU start: fetch the first command pair.
                        slot <= start_slot;
                        cur_b <= start.chan_b;
                        cur <= '0;
                        cur_start <= 1'b1;
                        if (start_ok) begin
                            mem_we <= 1'b0;
                            mem_addr <= start.cmd_addr;
                            priv_mem[start_slot].ptr <= start.cmd_addr;
                            state <= MIO_FETCH0;
                        end
                    end else if (gnt[1] || gnt[2]) begin
                        slot <= pick_slot;
                        cur_b <= pick_b;
                        cur <= pick;
                        cur_start <= 1'b0;
                        dev_end <= 1'b0;
                        if (!id_ok || !pick_rec.active) begin
                            // Unknown or idle channel: refuse at once.
                            dev_err <= 1'b1;
                            dev_rdata <= 32'h0000_0000;
                            dev_a_ack <= gnt[1];
                            dev_b_ack <= gnt[2];
                        end else begin
                            dev_err <= 1'b0;
                            mem_we <= pick.dir_in;
                            mem_addr <= {pick_rec.addr[31:2], 2'b00};
                            mem_be <= pick.wide ? 4'hf : byte_be;
                            mem_wdata <= pick.wide ? pick.data : {4{pick.data[7:0]}};
                            state <= MIO_XFER;
                        end
                    end else if (gnt[3]) begin
                        mem_we <= 1'b0;
                        mem_addr <= mv_src;
                        state <= MIO_MV_RD;
                    end
                end
                MIO_FETCH0: begin
                    if (mem_ack) begin
                        w0 <= mem_rdata;
                        mem_addr <= mem_addr + `MIO_WORD_STEP;
                        state <= MIO_FETCH1;
                    end
                end
                MIO_FETCH1: begin
                    if (mem_ack) begin
                        // Second word lands: the slot now holds the new command.
                        priv_mem[slot].order <= w0[`MIO_W0_ORDER_HI:`MIO_W0_ORDER_LO];
                        priv_mem[slot].addr <= {8'h00, w0[`MIO_W0_ADDR_HI:`MIO_W0_ADDR_LO]};
                        priv_mem[slot].cnt <= mem_rdata[`MIO_W1_CNT_HI:`MIO_W1_CNT_LO];
                        priv_mem[slot].dchain <= mem_rdata[`MIO_W1_DCHAIN];
                        priv_mem[slot].cchain <= mem_rdata[`MIO_W1_CCHAIN];
                        priv_mem[slot].irq_en <= mem_rdata[`MIO_W1_IRQ];
                        priv_mem[slot].ptr <= rec.ptr + `MIO_PAIR_STEP;
                        priv_mem[slot].active <= 1'b1;
                        // A chained device is answered only once its new command is in place.
                        if (!cur_start) begin
                            dev_a_ack <= ~cur_b;
                            dev_b_ack <= cur_b;
                        end
                        state <= MIO_IDLE;
                    end
                end
                MIO_XFER: begin
                    if (mem_ack) begin
                        dev_rdata <= cur.wide ? mem_rdata : rd_byte;
                        priv_mem[slot].addr <= rec.addr + {16'h0000, step};
                        priv_mem[slot].cnt <= last ? 16'h0000 : rec.cnt - step;
                        if (last && chain) begin
                            // Data chaining keeps the record open; command
                            // chaining closes it and starts the next one.
                            dev_end <= ~rec.dchain;
                            mem_we <= 1'b0;
                            mem_addr <= rec.ptr;
                            state <= MIO_FETCH0;
                        end else begin
                            if (last) begin
                                dev_end <= 1'b1;
                                priv_mem[slot].active <= 1'b0;
                                irq <= rec.irq_en;
                                irq_src <= '{is_move: 1'b0, chan_b: cur_b, id: cur.id};
                            end
                            dev_a_ack <= ~cur_b;
                            dev_b_ack <= cur_b;
                            state <= MIO_IDLE;
                        end
                    end
                end
                MIO_MV_RD: begin
                    if (mem_ack) begin
                        mem_we <= 1'b1;
                        mem_addr <= mv_dst;
                        mem_be <= 4'hf;
                        mem_wdata <= mem_rdata;
                        state <= MIO_MV_WR;
                    end
                end
                MIO_MV_WR: begin
                    if (mem_ack) begin
                        if (mv_cnt == 16'h0001) begin
                            irq <= mv_irq;
                            irq_src <= '{is_move: 1'b1, chan_b: 1'b0, id: 5'h00};
                        end
                        mem_we <= 1'b0;
                        state <= MIO_IDLE;
                    end
                end
                default: begin
                    state <= MIO_IDLE;
                end
            endcase
        end
    end

endmodule : mio_core

// ===== verification/mio_mem_model.sv
// Core memory model standing at the processor's memory port.
// Assumes one request at a time, held until its one-cycle ack.
`timescale 1ns/1ps

module mio_mem_model (
    // Clock, reset and wait states per access.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] lag,
    // Memory port of the processor.
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] store [int];
    logic [31:0] w;
    int waited;

    // Read data is valid only with the ack; it toggles otherwise so a late sample shows.
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!rst_n) begin
            waited <= 0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack) begin
            if (waited < int'(lag)) begin
                waited <= waited + 1;
            end else begin
                w = store.exists(int'(mem_addr[31:2])) ? store[int'(mem_addr[31:2])] : 32'h0;
                waited <= 0;
                mem_ack <= 1'b1;
                mem_rdata <= w;
                for (int i = 0; i < 4; i++) begin
                    if (mem_we && mem_be[i]) w[8*i +: 8] = mem_wdata[8*i +: 8];
                end
                store[int'(mem_addr[31:2])] = w;
            end
        end
    end
endmodule : mio_mem_model

// ===== verification/mio_core_assertions.sv
// Port-level checks on the multiplexing I/O processor core.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps

module mio_core_assertions
    import mio_pkg::*;
#(
    parameter int NUM_A = 24,
    parameter int NUM_B = 8
) (
    // Watched core ports.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start_valid,
    input wire mio_pkg::mio_start_s start,
    input wire logic start_ready,
    input wire logic move_valid,
    input wire mio_pkg::mio_move_s move,
    input wire logic irq,
    input wire mio_pkg::mio_irq_s irq_src,
    input wire logic dev_a_req,
    input wire mio_pkg::mio_dev_s dev_a,
    input wire logic dev_a_ack,
    input wire mio_pkg::mio_dev_s dev_b,
    input wire logic dev_b_ack,
    input wire logic dev_err,
    input wire logic move_ready,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack
);
    logic fetch_pend;
    wire id_in = start.chan_b ? start.id < NUM_B : start.id < NUM_A;

    // Marks the first command fetch so the second word's address can be tied to it.
    always_ff @(posedge clk) begin
        if (!rst_n || mem_ack) fetch_pend <= 1'b0;
        else if (start_valid && start_ready && id_in) fetch_pend <= 1'b1;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_START_FETCH: assert property (
        start_valid && start_ready && id_in
        |=> mem_req && !mem_we && mem_addr == $past(start.cmd_addr))
        else $error("first fetch not at command address");
    AST_FETCH_NEXT: assert property (
        fetch_pend && mem_ack |=> mem_req && !mem_we && mem_addr == $past(mem_addr) + 32'h4)
        else $error("second command word not fetched next");
    AST_MEM_HOLD: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
        else $error("memory request changed before ack");
    AST_START_IDLE: assert property (start_ready |-> move_ready)
        else $error("start offered while a move is pending");
    AST_MOVE_BLOCK: assert property (
        move_valid && move_ready && move.count != 16'h0 |=> !start_ready ##1 !start_ready)
        else $error("start offered during a move");
    AST_MOVE_IRQ: assert property (
        irq && irq_src.is_move |-> $past(mem_ack && mem_we) || $past(mem_ack && mem_we, 2))
        else $error("move interrupt not after a write");
    AST_IRQ_PULSE: assert property (irq |=> !irq)
        else $error("interrupt longer than one cycle");
    AST_ONE_ACK: assert property (!(dev_a_ack && dev_b_ack))
        else $error("both channels answered together");
    AST_ACK_CAUSE: assert property (dev_a_ack |-> $past(dev_a_req))
        else $error("answer without a request");
    AST_RANGE: assert property (
        (dev_a_ack && $past(dev_a.id) >= NUM_A) || (dev_b_ack && $past(dev_b.id) >= NUM_B)
        |-> dev_err)
        else $error("out-of-range id not refused");

    COV_MOVE_IRQ: cover property (irq && irq_src.is_move);
    COV_CHAIN_IRQ: cover property (irq && !irq_src.is_move);
    COV_REFUSE: cover property (dev_b_ack && dev_err);
endmodule : mio_core_assertions

bind mio_core mio_core_assertions #(.NUM_A(NUM_A), .NUM_B(NUM_B)) u_mio_core_assertions (
    .clk(clk), .rst_n(rst_n), .start_valid(start_valid), .start(start),
    .start_ready(start_ready), .move_valid(move_valid), .move(move), .irq(irq),
    .irq_src(irq_src), .dev_a_req(dev_a_req), .dev_a(dev_a), .dev_a_ack(dev_a_ack),
    .dev_b(dev_b), .dev_b_ack(dev_b_ack), .dev_err(dev_err), .move_ready(move_ready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack));

// ===== verification/mio_core_bench.sv
// Self-checking bench for the multiplexing I/O processor core.
// Assumes the bound checker and the memory model beside the core.
`timescale 1ns/1ps

module mio_core_bench;
    import mio_pkg::*;

    logic clk = 1'b0, rst_n = 1'b0, start_valid = 1'b0, move_valid = 1'b0;
    logic dev_a_req = 1'b0, dev_b_req = 1'b0;
    mio_start_s start = '0;
    mio_move_s move = '0;
    mio_dev_s dev_a = '0, dev_b = '0;
    mio_irq_s irq_src;
    logic start_ready, move_ready, irq, dev_a_ack, dev_b_ack, dev_end, dev_err;
    logic mem_req, mem_we, mem_ack;
    logic [31:0] dev_rdata, mem_addr, mem_wdata, mem_rdata;
    logic [3:0] mem_be, lag = 4'h0;
    int num_errors = 0, n_tests = 0;

    // Clock at 200 MHz.
    initial forever #2.5 clk = ~clk;

    mio_core u_mio_core (.clk(clk), .rst_n(rst_n), .start_valid(start_valid), .start(start),
        .start_ready(start_ready), .move_valid(move_valid), .move(move), .move_ready(move_ready),
        .irq(irq), .irq_src(irq_src), .dev_a_req(dev_a_req), .dev_a(dev_a), .dev_a_ack(dev_a_ack),
        .dev_b_req(dev_b_req), .dev_b(dev_b), .dev_b_ack(dev_b_ack), .dev_rdata(dev_rdata),
        .dev_end(dev_end), .dev_err(dev_err), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    mio_mem_model u_mio_mem_model (.clk(clk), .rst_n(rst_n), .lag(lag), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // Inputs always change 1 ns after the edge, never on it.
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic give_up;
        num_errors++;
        $display("Error at %0t: wait ran out", $time);
        close_out();
    endtask : give_up

    task automatic poke(input int a, input logic [31:0] v);
        u_mio_mem_model.store[a >> 2] = v;
    endtask : poke

    function automatic logic [31:0] peek(input int a);
        return u_mio_mem_model.store.exists(a >> 2) ? u_mio_mem_model.store[a >> 2] : 32'h0;
    endfunction : peek

    // Waits until four quiet idle cycles pass, noting any interrupt on the way.
    task automatic wait_idle(output logic s, output mio_irq_s src);
        int i, quiet;
        s = 1'b0;
        src = '0;
        quiet = 0;
        for (i = 0; i < 1000 && quiet < 4; i++) begin
            step();
            if (irq === 1'b1) {s, src} = {1'b1, irq_src};
            quiet = (move_ready === 1'b1 && mem_req === 1'b0) ? quiet + 1 : 0;
        end
        if (quiet < 4) give_up();
    endtask : wait_idle

    task automatic go(input logic b, input logic [4:0] id, input logic [31:0] cmd);
        int i;
        logic s;
        mio_irq_s src;
        step();
        start = '{b, id, cmd};
        start_valid = 1'b1;
        for (i = 0; i < 300 && start_ready !== 1'b1; i++) step();
        if (i == 300) give_up();
        step();
        start_valid = 1'b0;
        wait_idle(s, src);
    endtask : go

    // One controller request, held until its own ack; the answer is taken with the ack.
    task automatic serve(input logic b, input logic [4:0] id, input logic dir_in, input logic wide,
                         input logic [31:0] d, output logic e, output logic r,
                         output logic [31:0] rd);
        int i;
        step();
        {dev_a, dev_b} = {2{id, dir_in, wide, d}};
        {dev_b_req, dev_a_req} = b ? 2'b10 : 2'b01;
        for (i = 0; i < 300 && (b ? dev_b_ack : dev_a_ack) !== 1'b1; i++) step();
        if (i == 300) give_up();
        {e, r, rd} = {dev_end, dev_err, dev_rdata};
        {dev_a_req, dev_b_req} = 2'b00;
    endtask : serve

    // Loads one command pair, then runs n transfers plus one past the end.
    task automatic run_prog(input logic b, input logic [4:0] id, input logic wide,
                            input logic dir_in, input int n);
        int adr, cnt, stp, sh;
        logic e, r;
        logic [31:0] d, rd, m;
        lag = 4'($urandom % 4);
        adr = 32'h1000 + 32'h100 * id + 32'h4000 * b;
        stp = wide ? 4 : 1;
        cnt = n * stp;
        m = wide ? 32'hffff_ffff : 32'hff;
        poke(32'h40, {8'h01, 24'(adr)});
        poke(32'h44, {16'h0, 16'(cnt)});
        go(b, id, 32'h40);
        for (int k = 0; k <= n; k++) begin
            d = $urandom;
            sh = wide ? 0 : 8 * (adr % 4);
            if (!dir_in) poke(adr, d);
            serve(b, id, dir_in, wide, d, e, r, rd);
            check(r, k == n);
            if (k < n) begin
                check(e, cnt <= stp);
                check(dir_in ? (peek(adr) >> sh) & m : rd, dir_in ? d & m : (d >> sh) & m);
            end
            adr += stp;
            cnt -= stp;
        end
    endtask : run_prog

    initial begin
        logic e, r, s;
        logic [31:0] d, rd;
        mio_irq_s src;
        int i, ta, tb;
        void'($urandom(32'h111d));
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        wait_idle(s, src);
        check(s, 1'b0);
        // An inactive slot and an out-of-range id are refused.
        serve(1'b0, 5'd23, 1'b1, 1'b0, 32'h0, e, r, rd);
        check(r, 1'b1);
        serve(1'b1, 5'd8, 1'b1, 1'b0, 32'h0, e, r, rd);
        check(r, 1'b1);
        run_prog(1'b0, 5'd5, 1'b0, 1'b1, 3);
        run_prog(1'b1, 5'd7, 1'b1, 1'b0, 2);
        run_prog(1'b0, 5'd23, 1'b1, 1'b1, 2);
        // Simultaneous requests on both channels: channel A goes first.
        poke(32'h40, 32'h0100_8000);
        poke(32'h44, 32'h0000_0001);
        go(1'b0, 5'd2, 32'h40);
        go(1'b1, 5'd2, 32'h40);
        step();
        {dev_a, dev_b} = {2{5'd2, 1'b1, 1'b0, 32'h0}};
        {dev_a_req, dev_b_req, ta, tb} = {2'b11, 64'h0};
        for (i = 1; i < 300 && (dev_a_req || dev_b_req); i++) begin
            step();
            if (dev_a_ack === 1'b1) {ta, dev_a_req} = {i, 1'b0};
            if (dev_b_ack === 1'b1) {tb, dev_b_req} = {i, 1'b0};
        end
        check(ta != 0 && ta < tb, 1'b1);
        // Data chain, then command chain, then a last pair asking for an interrupt.
        for (int k = 0; k < 3; k++) begin
            poke(32'h40 + 8 * k, 32'h0100_6000 + 32'h10 * k);
            poke(32'h44 + 8 * k, 32'h0000_0001 | (32'h8000_0000 >> k));
        end
        go(1'b1, 5'd3, 32'h40);
        for (int k = 0; k < 3; k++) begin
            d = $urandom;
            serve(1'b1, 5'd3, 1'b1, 1'b0, d, e, r, rd);
            check(irq, k == 2);
            check(e, k != 0);
            check(peek(32'h6000 + 32'h10 * k) & 32'hff, d & 32'hff);
        end
        wait_idle(s, src);
        check(irq_src, {1'b0, 1'b1, 5'd3});
        // Memory moves, with and without a completion interrupt.
        for (int j = 0; j < 2; j++) begin
            for (int k = 0; k < 3; k++) poke(32'h7000 + 4 * k, $urandom);
            lag = 4'($urandom % 4);
            step();
            move = '{32'h7000, 32'h7800 + 32'h100 * j, 16'(3 - 2 * j), j == 0};
            move_valid = 1'b1;
            for (i = 0; i < 300 && move_ready !== 1'b1; i++) step();
            if (i == 300) give_up();
            step();
            move_valid = 1'b0;
            wait_idle(s, src);
            check(s, j == 0);
            check(irq_src.is_move, 1'b1);
            for (int k = 0; k < 3 - 2 * j; k++) begin
                check(peek(32'h7800 + 32'h100 * j + 4 * k), peek(32'h7000 + 4 * k));
            end
        end
        close_out();
    end
endmodule : mio_core_bench
